// ==== pamux_ctrl.sv ====
// reset-circuit disable control and port A pin configuration register slice
//
// Notes on behaviour
// - power-up event resets chip while circuit armed
// - key 0x5AA5 in bits 15:0 disarms circuit
// - any other key value re-arms circuit
// - every other reset source re-arms circuit
// - key writes ignored while register protection on
// - upper half bits enable per-pin schmitt trigger
// - port configuration resets to all zero
// - pin 14: gpio, pwm 2 or bus bit 15
// - pin 13: gpio, pwm 1 or bus bit 14
//
// Implementation choice: strobed register access.
`default_nettype none

module pamux_ctrl #(
  parameter int ADDR_W = 12  // register byte-address width, bits
) (
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [pamux_pkg::PAMUX_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [pamux_pkg::PAMUX_DATA_W-1:0] reg_rdata,
  // level from the protection unit, high while protected writes are allowed
  input wire logic write_unlocked,
  // reset sources
  input wire logic power_up_event,
  input wire logic reset_pin_event,
  input wire logic watchdog_reset,
  input wire logic low_voltage_reset,
  input wire logic brownout_detector_reset,
  input wire logic debug_probe_reset,
  input wire logic software_chip_reset,
  // alternate-function controls held elsewhere
  input wire logic pin15_audio_clock_select,
  input wire logic external_bus_enable,
  input wire logic external_bus_high_byte_enable7,
  input wire logic external_bus_high_byte_enable6,
  // outputs
  output logic chip_reset_request,
  output logic por_circuit_enabled,
  output logic [pamux_pkg::PAMUX_PINS-1:0] port_a_schmitt_enable,
  output logic [pamux_pkg::PAMUX_PINS-1:0] port_a_function_select,
  output logic [2:0] pin15_function,
  output logic [2:0] pin14_function,
  output logic [2:0] pin13_function
);
  import pamux_pkg::*;

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  // the highest offset must be reachable on the address port
  if (ADDR_W < 6 || ADDR_W > 12) begin : g_bad_addr_w
    $error("pamux_ctrl: ADDR_W must be between 6 and 12");
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  // address match against a package offset, cut to the port width
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
    addr_hit = (addr == off[ADDR_W-1:0]);
  endfunction

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [PAMUX_KEY_W-1:0] key;    // reset-circuit disable key field
    logic [PAMUX_DATA_W-1:0] cfg;   // port A configuration word
    logic [PAMUX_DATA_W-1:0] rdata; // read data, valid one cycle after a read
    logic reset_req;                // chip reset request pulse
  } pamux_state_t;

  pamux_state_t state;       // registered state
  pamux_state_t next_state;  // next value

  logic rearm;        // any non power-up reset source active
  logic key_wr;       // write strobe aimed at the control register
  logic cfg_wr;       // write strobe aimed at the configuration register
  logic por_armed;    // circuit is live in the current cycle

  // any of these resets the chip elsewhere and must leave the circuit armed
  assign rearm = reset_pin_event | watchdog_reset | low_voltage_reset |
                 brownout_detector_reset | debug_probe_reset | software_chip_reset;
  assign key_wr = reg_write && addr_hit(reg_addr, PAMUX_OFF_POR_CTRL);
  assign cfg_wr = reg_write && addr_hit(reg_addr, PAMUX_OFF_PA_CFG);
  // only the exact key disarms; every other value leaves it live
  assign por_armed = (state.key != PAMUX_DISABLE_KEY);

  // ==========================================================================
  // next-state logic
  // ==========================================================================
  always_comb begin
    next_state = state;

    // key field: protected, low half only
    if (key_wr && write_unlocked) begin
      next_state.key = reg_wdata[PAMUX_KEY_LSB +: PAMUX_KEY_W];
    end
    // hardware re-arm beats a software write in the same cycle
    if (rearm) begin
      next_state.key = PAMUX_KEY_RESET;
    end

    // configuration word: not protected, every bit writable
    if (cfg_wr) begin
      next_state.cfg = reg_wdata;
    end

    // power-up while armed requests a whole-chip reset for one cycle
    next_state.reset_req = power_up_event && por_armed;

    // read data: stands only in the cycle after the read strobe
    next_state.rdata = PAMUX_RDATA_IDLE;
    if (reg_read) begin
      if (addr_hit(reg_addr, PAMUX_OFF_POR_CTRL)) begin
        // reserved upper half reads as zero
        next_state.rdata = {PAMUX_RSVD_ZERO, state.key};
      end else if (addr_hit(reg_addr, PAMUX_OFF_PA_CFG)) begin
        next_state.rdata = state.cfg;
      end else begin
        // unmapped address answers zero
        next_state.rdata = PAMUX_RDATA_IDLE;
      end
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state.key <= PAMUX_KEY_RESET;
      state.cfg <= PAMUX_PA_CFG_RESET;
      state.rdata <= PAMUX_RDATA_IDLE;
      state.reset_req <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign reg_rdata = state.rdata;
  assign chip_reset_request = state.reset_req;
  assign por_circuit_enabled = por_armed;
  assign port_a_schmitt_enable = state.cfg[PAMUX_SCHMITT_LSB +: PAMUX_PINS];
  assign port_a_function_select = state.cfg[PAMUX_FSEL_LSB +: PAMUX_PINS];

  // ==========================================================================
  // per-pin function decoders
  // ==========================================================================
  // pin 15 ignores the bus enables, its alternate comes from the audio selector
  pamux_pin_decode #(
    .BUS_PIN(1'b0)
  ) u_pin15 (
    .mclk(mclk),
    .resetn(resetn),
    .func_bit(state.cfg[PAMUX_PIN15]),
    .alt_select(pin15_audio_clock_select),
    .bus_enable(1'b0),
    .high_byte_enable(1'b0),
    .pin_function(pin15_function)
  );

  // pin 14 carries bus address/data bit 15
  pamux_pin_decode #(
    .BUS_PIN(1'b1)
  ) u_pin14 (
    .mclk(mclk),
    .resetn(resetn),
    .func_bit(state.cfg[PAMUX_PIN14]),
    .alt_select(1'b0),
    .bus_enable(external_bus_enable),
    .high_byte_enable(external_bus_high_byte_enable7),
    .pin_function(pin14_function)
  );

  // pin 13 carries bus address/data bit 14
  pamux_pin_decode #(
    .BUS_PIN(1'b1)
  ) u_pin13 (
    .mclk(mclk),
    .resetn(resetn),
    .func_bit(state.cfg[PAMUX_PIN13]),
    .alt_select(1'b0),
    .bus_enable(external_bus_enable),
    .high_byte_enable(external_bus_high_byte_enable6),
    .pin_function(pin13_function)
  );

  // ==========================================================================
  // checks
  // ==========================================================================
  // an unlocked write of the disable key with no re-arm source
  sequence seq_key_disable;
    key_wr && write_unlocked && !rearm &&
      reg_wdata[PAMUX_KEY_LSB +: PAMUX_KEY_W] == PAMUX_DISABLE_KEY;
  endsequence

  // a power-up event with no re-arm source and no key write
  sequence seq_quiet_power_up;
    power_up_event && !rearm && !key_wr;
  endsequence

  key_locked_a: assert property (@(posedge mclk) disable iff (!resetn)
    (key_wr && !write_unlocked && !rearm) |=> $stable(state.key))
    else $error("protected key changed while locked");

  key_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    seq_key_disable |=> !por_circuit_enabled)
    else $error("disable key did not disarm circuit");

  por_masked_a: assert property (@(posedge mclk) disable iff (!resetn)
    seq_key_disable ##1 seq_quiet_power_up |=> !chip_reset_request)
    else $error("reset requested while circuit disarmed");

  por_fire_a: assert property (@(posedge mclk) disable iff (!resetn)
    (power_up_event && por_circuit_enabled) |=> chip_reset_request)
    else $error("power-up did not request chip reset");

  rearm_src_a: assert property (@(posedge mclk) disable iff (!resetn)
    rearm |=> por_circuit_enabled && state.key == PAMUX_KEY_RESET)
    else $error("reset source did not re-arm circuit");

  key_other_a: assert property (@(posedge mclk) disable iff (!resetn)
    (key_wr && write_unlocked &&
      reg_wdata[PAMUX_KEY_LSB +: PAMUX_KEY_W] != PAMUX_DISABLE_KEY)
    |=> por_circuit_enabled)
    else $error("non-key value left circuit disarmed");

  schmitt_wr_a: assert property (@(posedge mclk) disable iff (!resetn)
    cfg_wr |=> port_a_schmitt_enable == $past(reg_wdata[PAMUX_SCHMITT_LSB +: PAMUX_PINS]))
    else $error("schmitt enables not taken from write");

  rsvd_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_read && addr_hit(reg_addr, PAMUX_OFF_POR_CTRL))
    |=> reg_rdata[PAMUX_DATA_W-1:PAMUX_KEY_W] == PAMUX_RSVD_ZERO &&
        reg_rdata[PAMUX_KEY_W-1:0] == $past(state.key))
    else $error("control register read wrong");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    !reg_read |=> reg_rdata == PAMUX_RDATA_IDLE)
    else $error("read data outside read cycle");

endmodule

`default_nettype wire

// ==== pamux_ctrl_tb_top.sv ====
// self-checking bench for the port A mux and reset-circuit control slice
`default_nettype none

module pamux_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pamux_pkg::*;

  // ==========================================================================
  // stimulus and observed signals
  // ==========================================================================
  logic mclk;                     // 40 MHz system clock
  logic resetn;                   // async reset, active low
  logic [11:0] reg_addr;          // register byte address
  logic [31:0] reg_wdata;         // write data
  logic [31:0] reg_rdata;         // read data, one cycle after the strobe
  logic reg_write;                // write strobe
  logic reg_read;                 // read strobe
  logic write_unlocked;           // protection state from outside
  logic power_up_event;           // power-up detector
  logic [5:0] rearm;              // pin, watchdog, low voltage, brownout, probe, software
  logic pin15_audio_clock_select; // pin 15 alt selector
  logic external_bus_enable;      // bus enable
  logic external_bus_high_byte_enable7; // high-byte enable 7
  logic external_bus_high_byte_enable6; // high-byte enable 6
  logic chip_reset_request;
  logic por_circuit_enabled;
  logic [15:0] port_a_schmitt_enable;
  logic [15:0] port_a_function_select;
  logic [2:0] pin15_function;
  logic [2:0] pin14_function;
  logic [2:0] pin13_function;
  int err_total;                  // mismatches seen
  int samples_checked;            // comparisons made
  logic [31:0] rd;                // last read word

  pamux_ctrl pamux_ctrl_i (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .write_unlocked(write_unlocked), .power_up_event(power_up_event),
    .reset_pin_event(rearm[0]), .watchdog_reset(rearm[1]), .low_voltage_reset(rearm[2]),
    .brownout_detector_reset(rearm[3]), .debug_probe_reset(rearm[4]),
    .software_chip_reset(rearm[5]), .pin15_audio_clock_select(pin15_audio_clock_select),
    .external_bus_enable(external_bus_enable),
    .external_bus_high_byte_enable7(external_bus_high_byte_enable7),
    .external_bus_high_byte_enable6(external_bus_high_byte_enable6),
    .chip_reset_request(chip_reset_request), .por_circuit_enabled(por_circuit_enabled),
    .port_a_schmitt_enable(port_a_schmitt_enable),
    .port_a_function_select(port_a_function_select),
    .pin15_function(pin15_function), .pin14_function(pin14_function),
    .pin13_function(pin13_function)
  );

  // ==========================================================================
  // clock and hang guard
  // ==========================================================================
  // free-running clock, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // cuts a hang short well above the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    final_report();
  end

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one-cycle write strobe, strobe dropped at the edge that takes it
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  // read data is sampled in the single cycle where it stands
  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // key readback plus the circuit state it implies
  task automatic check_key(input logic [15:0] k);
    logic [31:0] d;
    reg_rd(PAMUX_OFF_POR_CTRL, d);
    check(d, {PAMUX_RSVD_ZERO, k});
    check(32'(por_circuit_enabled), 32'(k != PAMUX_DISABLE_KEY));
  endtask

  // one-cycle power-up pulse, request seen right after the edge that takes it
  task automatic power_pulse(input logic exp);
    @(posedge mclk);
    power_up_event <= 1'b1;
    @(posedge mclk);
    power_up_event <= 1'b0;
    #1;
    check(32'(chip_reset_request), 32'(exp));
  endtask

  // expected function of a bus-capable pin
  function automatic pamux_fn_t exp_bus(input logic f, input logic en, input logic hb);
    if (!f) return PAMUX_FN_GPIO;
    if (!en && !hb) return PAMUX_FN_PWM;
    if (en && hb) return PAMUX_FN_ALT;
    return PAMUX_FN_GPIO;
  endfunction

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    err_total = 0;
    samples_checked = 0;
    resetn = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    write_unlocked = 1'b1;
    power_up_event = 1'b0;
    rearm = 6'h00;
    pin15_audio_clock_select = 1'b0;
    external_bus_enable = 1'b0;
    external_bus_high_byte_enable7 = 1'b0;
    external_bus_high_byte_enable6 = 1'b0;
    repeat (6) @(posedge mclk);
    check(32'(pin15_function), 32'(PAMUX_FN_GPIO));
    resetn <= 1'b1;
    // reset values, then the read word falls back to idle
    check_key(PAMUX_KEY_RESET);
    reg_rd(PAMUX_OFF_PA_CFG, rd);
    check(rd, PAMUX_PA_CFG_RESET);
    @(posedge mclk);
    #1;
    check(reg_rdata, PAMUX_RDATA_IDLE);
    check({port_a_schmitt_enable, port_a_function_select}, PAMUX_PA_CFG_RESET);
    power_pulse(1'b1);
    @(posedge mclk);
    #1;
    check(32'(chip_reset_request), 32'h0000_0000);
    // key write while protected is dropped
    @(posedge mclk);
    write_unlocked <= 1'b0;
    reg_wr(PAMUX_OFF_POR_CTRL, 32'h0000_5AA5);
    check_key(PAMUX_KEY_RESET);
    // unlocked key write, reserved half written with ones
    @(posedge mclk);
    write_unlocked <= 1'b1;
    reg_wr(PAMUX_OFF_POR_CTRL, 32'hFFFF_5AA5);
    // power-up in the cycle right after the key lands is already masked
    power_up_event <= 1'b1;
    @(posedge mclk);
    power_up_event <= 1'b0;
    #1;
    check(32'(chip_reset_request), 32'h0000_0000);
    check_key(PAMUX_DISABLE_KEY);
    power_pulse(1'b0);
    // protected overwrite must not re-arm
    @(posedge mclk);
    write_unlocked <= 1'b0;
    reg_wr(PAMUX_OFF_POR_CTRL, 32'h0000_0000);
    check_key(PAMUX_DISABLE_KEY);
    @(posedge mclk);
    write_unlocked <= 1'b1;
    // key off by one re-arms the circuit
    reg_wr(PAMUX_OFF_POR_CTRL, 32'h0000_5AA4);
    check_key(16'h5AA4);
    power_pulse(1'b1);
    // each other reset source re-arms
    for (int i = 0; i < 6; i++) begin
      reg_wr(PAMUX_OFF_POR_CTRL, 32'h0000_5AA5);
      check_key(PAMUX_DISABLE_KEY);
      @(posedge mclk);
      rearm[i] <= 1'b1;
      @(posedge mclk);
      rearm[i] <= 1'b0;
      #1;
      check(32'(por_circuit_enabled), 32'h0000_0001);
      check_key(PAMUX_KEY_RESET);
    end
    // schmitt and function halves land on their own ports
    reg_wr(PAMUX_OFF_PA_CFG, 32'hA5C3_6001);
    reg_rd(PAMUX_OFF_PA_CFG, rd);
    check(rd, 32'hA5C3_6001);
    check(32'(port_a_schmitt_enable), 32'h0000_A5C3);
    check(32'(port_a_function_select), 32'h0000_6001);
    // unmapped address: write dropped, read zero
    reg_wr(12'h028, 32'hFFFF_FFFF);
    reg_rd(12'h028, rd);
    check(rd, 32'h0000_0000);
    reg_rd(PAMUX_OFF_PA_CFG, rd);
    check(rd, 32'hA5C3_6001);
    // every combination of function bit and alternate controls
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk);
      pin15_audio_clock_select <= i[3];
      external_bus_enable <= i[2];
      external_bus_high_byte_enable7 <= i[1];
      external_bus_high_byte_enable6 <= i[0];
      reg_wr(PAMUX_OFF_PA_CFG, i[4] ? 32'h0000_E000 : 32'h0000_0000);
      repeat (2) @(posedge mclk);
      #1;
      check(32'(pin15_function), 32'(!i[4] ? PAMUX_FN_GPIO :
            (i[3] ? PAMUX_FN_ALT : PAMUX_FN_PWM)));
      check(32'(pin14_function), 32'(exp_bus(i[4], i[2], i[1])));
      check(32'(pin13_function), 32'(exp_bus(i[4], i[2], i[0])));
    end
    // second reset in mid-run: circuit re-armed, configuration cleared
    reg_wr(PAMUX_OFF_POR_CTRL, 32'h0000_5AA5);
    reg_wr(PAMUX_OFF_PA_CFG, 32'hFFFF_FFFF);
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    #1;
    // outputs fall back while reset is still held, no clock needed
    check(32'(por_circuit_enabled), 32'h0000_0001);
    check(32'(pin14_function), 32'(PAMUX_FN_GPIO));
    check(32'(port_a_schmitt_enable), 32'h0000_0000);
    @(posedge mclk);
    resetn <= 1'b1;
    check_key(PAMUX_KEY_RESET);
    reg_rd(PAMUX_OFF_PA_CFG, rd);
    check(rd, PAMUX_PA_CFG_RESET);
    final_report();
  end

endmodule

`default_nettype wire

// ==== pamux_pin_decode.sv ====
// function decoder for one multi-function pin of port A, registered output
`default_nettype none

module pamux_pin_decode #(
  parameter bit BUS_PIN = 1'b1  // 1: alt function is a bus line; 0: alt picked by alt_select
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic func_bit,
  input wire logic alt_select,
  input wire logic bus_enable,
  input wire logic high_byte_enable,
  output logic [2:0] pin_function
);
  import pamux_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    pamux_fn_t fn;  // currently selected pin function
  } pamux_dec_state_t;

  pamux_dec_state_t state;       // registered state
  pamux_dec_state_t next_state;  // next value

  // decode of the function bit against the alternate-function controls
  always_comb begin
    next_state = state;
    if (!func_bit) begin
      // function bit clear always gives gpio
      next_state.fn = PAMUX_FN_GPIO;
    end else if (!BUS_PIN) begin
      // audio-clock pin: selector alone chooses pwm or clock
      next_state.fn = alt_select ? PAMUX_FN_ALT : PAMUX_FN_PWM;
    end else if (!bus_enable && !high_byte_enable) begin
      next_state.fn = PAMUX_FN_PWM;
    end else if (bus_enable && high_byte_enable) begin
      next_state.fn = PAMUX_FN_ALT;
    end else begin
      // mixed enables are undefined; falling back to gpio keeps the pad harmless
      next_state.fn = PAMUX_FN_GPIO;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= '{fn: PAMUX_FN_GPIO};
    end else begin
      state <= next_state;
    end
  end

  assign pin_function = state.fn;

  // ==========================================================================
  // checks
  // ==========================================================================
  dec_gpio_a: assert property (@(posedge mclk) disable iff (!resetn)
    !func_bit |=> pin_function == PAMUX_FN_GPIO)
    else $error("pin not gpio with function bit clear");

  dec_alt_a: assert property (@(posedge mclk) disable iff (!resetn)
    (func_bit && (BUS_PIN ? (bus_enable && high_byte_enable) : alt_select))
    |=> pin_function == PAMUX_FN_ALT)
    else $error("alternate function not selected");

  dec_pwm_a: assert property (@(posedge mclk) disable iff (!resetn)
    (func_bit && (BUS_PIN ? (!bus_enable && !high_byte_enable) : !alt_select))
    |=> pin_function == PAMUX_FN_PWM)
    else $error("pwm function not selected");

endmodule

`default_nettype wire

// ==== pamux_pkg.sv ====
// shared constants and types for the port A mux and reset-circuit control slice
`default_nettype none

package pamux_pkg;

  // ==========================================================================
  // register map (byte offsets from the control bank base)
  // ==========================================================================
  localparam int PAMUX_DATA_W = 32;                   // register bus data width
  localparam logic [11:0] PAMUX_OFF_POR_CTRL = 12'h024; // power_on_reset_control
  localparam logic [11:0] PAMUX_OFF_PA_CFG = 12'h030;   // port_a_function_and_input_type

  // ==========================================================================
  // power_on_reset_control fields
  // ==========================================================================
  localparam int PAMUX_KEY_LSB = 0;                   // disable key field low bit
  localparam int PAMUX_KEY_W = 16;                    // disable key field width
  localparam logic [15:0] PAMUX_DISABLE_KEY = 16'h5AA5; // value that turns the circuit off
  localparam logic [15:0] PAMUX_KEY_RESET = 16'h0000;   // key after any reset (circuit armed)
  localparam logic [15:0] PAMUX_RSVD_ZERO = 16'h0000;   // reserved upper half reads this

  // ==========================================================================
  // port A configuration fields
  // ==========================================================================
  localparam int PAMUX_PINS = 16;                     // pins on port A
  localparam int PAMUX_FSEL_LSB = 0;                  // function select bits [15:0]
  localparam int PAMUX_SCHMITT_LSB = 16;              // schmitt enables [31:16]
  localparam int PAMUX_PIN15 = 15;                    // function bit of pin 15
  localparam int PAMUX_PIN14 = 14;                    // function bit of pin 14
  localparam int PAMUX_PIN13 = 13;                    // function bit of pin 13
  localparam logic [31:0] PAMUX_PA_CFG_RESET = 32'h0000_0000; // all gpio, no schmitt
  localparam logic [31:0] PAMUX_RDATA_IDLE = 32'h0000_0000;   // read data outside a read

  // ==========================================================================
  // pin function codes, one-hot
  // ==========================================================================
  typedef enum logic [2:0] {
    PAMUX_FN_GPIO = 3'b001,  // plain general-purpose i/o
    PAMUX_FN_PWM  = 3'b010,  // pulse-width output
    PAMUX_FN_ALT  = 3'b100   // audio clock or external bus line
  } pamux_fn_t;

endpackage

`default_nettype wire
